// File: hdl/fns_synth_core.sv
/*
 Digital core of a fractional-N synthesizer: serial word decode and
 staging, reference divider, main divider control, fractional
 accumulator, phase detector, lock and test output selection.
 Assumes clk is the reference input clock and that the prescaler
 output toggles slower than half of clk.
*/
`timescale 1ns/1ps
`default_nettype none

module fns_synth_core
   import fns_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic serial_clk,
   input wire logic serial_data,
   input wire logic latch_enable,
   input wire logic prescaler_out,
   input wire logic divider_probe_input,
   output logic [1:0] prescaler_ratio,
   output logic prescaler_enable,
   output logic ref_input_enable,
   output logic pump_output_up,
   output logic pump_output_down,
   output logic [7:0] pump_current_level,
   output logic comp_enable,
   output logic [2:0] fraction_accumulator_value,
   output logic lock_out
);

   // Serial domain word and its latch crossing
   logic [WORD_W-1:0] shift_word; // Frozen while latch is high
   logic le_meta; // First synchroniser stage
   logic le_sync; // Latch level in clk domain
   logic le_prev; // For rising edge detect

   // Held registers
   fns_setup_t setup; // Setup word contents
   fns_test_t test; // Test word contents
   logic [7:0] cn_tmp; // Staged pump factor
   logic [1:0] pr_tmp; // Staged prescaler type
   fns_div_cfg_t staged; // Divider word awaiting sync
   logic pending; // Staged word not yet applied
   fns_div_cfg_t working; // Values in use

   // Prescaler path
   logic ps_meta;
   logic ps_sync;
   logic pb_meta;
   logic pb_sync;
   logic div_prev; // Previous divider input level

   // Main divider
   fns_md_state_t md_state;
   logic [12:0] md_count; // Cycles left in this phase
   logic stretch_req; // Overflow awaits a 65 cycle
   logic [2:0] acc; // Fractional accumulator
   logic md_p1; // Main pulse delay chain
   logic md_p2;
   logic md_p3;

   // Reference divider
   logic [11:0] ref_count;
   logic [2:0] post_count;
   logic ref_pulse; // Selected reference output

   // Phase detector and lock
   logic pd_up;
   logic pd_down;
   logic [3:0] gap_count; // Cycles with only one side set
   logic lock_ok;

   // Serial shift register lives on the serial clock
   fns_serial_shift #(
      .WIDTH(WORD_W)
   ) u_shift (
      .serial_clk(serial_clk),
      .rst(rst),
      .serial_data(serial_data),
      .latch_enable(latch_enable),
      .shift_word(shift_word)
   );

   // Latch level crossing; word is stable once the level has crossed
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         le_meta <= 1'b0;
         le_sync <= 1'b0;
         le_prev <= 1'b0;
      end else if (ce) begin
         le_meta <= latch_enable;
         le_sync <= le_meta;
         le_prev <= le_sync;
      end
   end

   // Word decode views
   wire latch_strobe = le_sync & ~le_prev;
   wire [3:0] addr4 = shift_word[ADDR_W-1:0];
   wire is_div = (shift_word[0] == ADDR_DIV);
   fns_setup_word_t setup_w;
   fns_pump_word_t pump_w;
   fns_test_word_t test_w;
   fns_long_divider_word_t long_w;
   fns_short_divider_word_t short_w;
   assign setup_w = fns_setup_word_t'(shift_word[SHORT_W-1:0]);
   assign pump_w = fns_pump_word_t'(shift_word[SHORT_W-1:0]);
   assign test_w = fns_test_word_t'(shift_word[SHORT_W-1:0]);
   assign long_w = fns_long_divider_word_t'(shift_word);
   assign short_w = fns_short_divider_word_t'(shift_word[SHORT_W-1:0]);

   // Write strobes, one per word type
   wire wr_setup = latch_strobe & ~is_div & (addr4 == ADDR_SETUP);
   wire wr_pump = latch_strobe & ~is_div & (addr4 == ADDR_PUMP);
   wire wr_test = latch_strobe & ~is_div & (addr4 == ADDR_TEST);
   wire wr_div = latch_strobe & is_div;

   // Divider word body: long words carry the pump factor up front
   wire [7:0] div_cn = setup.word_format_select ?
      long_w.pump_current_factor : cn_tmp;
   wire [11:0] div_m64 = setup.word_format_select ?
      long_w.body.mod64_cycle_count : short_w.mod64_cycle_count;
   wire [7:0] div_field = setup.word_format_select ?
      long_w.body.count_field : short_w.count_field;
   wire [2:0] div_frac = setup.word_format_select ?
      long_w.body.fraction_increment : short_w.fraction_increment;

   // Setup and test registers; setup also wipes the test word
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         setup <= '0;
         test <= '0;
      end else if (ce) begin
         if (wr_setup) begin
            setup <= {setup_w.synth_enable, setup_w.ref_output_select,
                      setup_w.ref_divide_ratio,
                      setup_w.fraction_modulus_select,
                      setup_w.word_format_select};
            test <= '0;
         end else if (wr_test) begin
            test <= {1'b1, test_w.test_select_hi, test_w.test_select_lo};
         end
      end
   end

   // Pump word only stages; nothing takes effect until a divider load
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cn_tmp <= '0;
         pr_tmp <= '0;
      end else if (ce && wr_pump) begin
         cn_tmp <= pump_w.pump_current_factor;
         pr_tmp <= pump_w.prescaler_select;
      end
   end

   // Sync point: last 64-count edge of a main cycle
   wire div_in = ps_sync ^ pb_sync;
   wire main_edge = setup.synth_enable & div_in & ~div_prev;
   wire md_last = (md_count <= COUNT_LAST);
   wire main_end = main_edge & (md_state == MD_M64) & md_last;
   wire load_now = main_end & pending;

   // Staged divider word; a new latch wins over the load clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         staged <= '0;
         pending <= 1'b0;
      end else if (ce) begin
         if (wr_div) begin
            staged <= {div_m64, div_field, div_field[7:4], pr_tmp,
                       div_frac, div_cn};
            pending <= 1'b1;
         end else if (load_now) begin
            pending <= 1'b0;
         end
      end
   end

   // Working values change only at the sync point
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         working <= '0;
      end else if (ce && load_now) begin
         working <= staged;
      end
   end

   // Prescaler and probe pins are asynchronous: two stages each
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ps_meta <= 1'b0;
         ps_sync <= 1'b0;
         pb_meta <= 1'b0;
         pb_sync <= 1'b0;
         div_prev <= 1'b0;
      end else if (ce) begin
         ps_meta <= prescaler_out;
         ps_sync <= ps_meta;
         pb_meta <= divider_probe_input;
         pb_sync <= pb_meta;
         div_prev <= div_in;
      end
   end

   // Phase lengths from the values that the next cycle will use
   fns_div_cfg_t cfg_sel;
   assign cfg_sel = load_now ? staged : working;
   wire three = (cfg_sel.prescaler_select == PR_THREE);
   wire [12:0] n65 = three ? {9'h000, cfg_sel.mod65_cycle_count[3:0]} :
                             {5'h00, cfg_sel.mod65_cycle_count};
   wire [12:0] n72 = {9'h000, cfg_sel.mod72_cycle_count} + M72_EXTRA;
   wire [12:0] n64 = {1'b0, cfg_sel.mod64_cycle_count} + M64_EXTRA;

   // Phase that follows the 65 phase, or starts a cycle without one
   wire fns_md_state_t after65 = three ? MD_M72 : MD_M64;
   wire [12:0] after65_count = three ? n72 : n64;
   wire fns_md_state_t first_state = (n65 != 13'h0000) ? MD_M65 : after65;
   wire [12:0] first_count = (n65 != 13'h0000) ? n65 : after65_count;

   // Next phase and count on each divider input edge
   fns_md_state_t next_state;
   logic [12:0] next_count;
   always_comb begin
      next_state = md_state;
      next_count = md_count;
      if (main_edge) begin
         unique case (md_state)
            MD_M65: begin // 65 cycles counted down first
               if (md_last) begin
                  next_state = after65;
                  next_count = after65_count;
               end else begin
                  next_count = md_count - COUNT_LAST;
               end
            end
            MD_M72: begin // Only with three-modulus type
               if (md_last) begin
                  next_state = MD_M64;
                  next_count = n64;
               end else begin
                  next_count = md_count - COUNT_LAST;
               end
            end
            MD_M64: begin // Counting down; cycle ends here
               if (md_last) begin
                  next_state = first_state;
                  next_count = first_count;
               end else begin
                  next_count = md_count - COUNT_LAST;
               end
            end
            default: begin // Illegal code recovers to a fresh cycle
               next_state = first_state;
               next_count = first_count;
            end
         endcase
      end
   end

   // Only a 64-phase edge ends the stretch; a 65 or 72 edge must keep it
   wire m64_edge = main_edge & (md_state == MD_M64);

   // Ratio seen by the prescaler; one 64 cycle becomes 65 on overflow
   wire [1:0] next_ratio = (next_state == MD_M65) ? RATIO_65 :
                           (next_state == MD_M72) ? RATIO_72 :
                           (stretch_req & ~m64_edge) ? RATIO_65 :
                           RATIO_64;

   // Main divider state
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         md_state <= MD_M64;
         md_count <= M64_EXTRA;
         prescaler_ratio <= RATIO_64;
      end else if (ce) begin
         md_state <= next_state;
         md_count <= next_count;
         prescaler_ratio <= next_ratio;
      end
   end

   // Accumulator: sum wide enough to hold the carry before wrapping
   wire [3:0] q_mod = setup.fraction_modulus_select ? QMOD8 : QMOD5;
   wire [3:0] acc_sum = {1'b0, acc} + {1'b0, cfg_sel.fraction_increment};
   wire acc_ovf = (acc_sum >= q_mod);
   wire [3:0] acc_wrap = acc_sum - q_mod;
   wire [2:0] next_acc = acc_ovf ? acc_wrap[2:0] : acc_sum[2:0];

   // Add increment at each cycle end; overflow requests a stretch
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         acc <= '0;
         stretch_req <= 1'b0;
      end else if (ce) begin
         if (main_end) begin
            acc <= next_acc;
         end
         // Set wins: a fresh overflow is never lost to the clear
         if (main_end && acc_ovf) begin
            stretch_req <= 1'b1;
         end else if (main_edge && md_state == MD_M64 && stretch_req) begin
            stretch_req <= 1'b0;
         end
      end
   end

   // Pulse is delayed two cycles so the window can open one cycle before it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         md_p1 <= 1'b0;
         md_p2 <= 1'b0;
         md_p3 <= 1'b0;
      end else if (ce) begin
         md_p1 <= main_end;
         md_p2 <= md_p1;
         md_p3 <= md_p2;
      end
   end

   // Ratios below the minimum would make the divider stall
   wire [11:0] nr_eff = (setup.ref_divide_ratio < NR_MIN) ?
      NR_MIN : setup.ref_divide_ratio;
   wire ref_tick = setup.synth_enable & (ref_count <= REF_LAST);
   wire [2:0] post_mask = POST_MASK[setup.ref_output_select];
   wire ref_sel_tick = ref_tick &
      ((post_count & post_mask) == post_mask);

   // Reference divider and three-bit post counter; halted when off
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ref_count <= NR_MIN;
         post_count <= '0;
         ref_pulse <= 1'b0;
      end else if (ce) begin
         ref_pulse <= ref_sel_tick;
         if (setup.synth_enable) begin
            if (ref_tick) begin
               ref_count <= nr_eff;
               post_count <= post_count + 3'h1;
            end else begin
               ref_count <= ref_count - REF_LAST;
            end
         end
      end
   end

   // Two-flop detector; both set means clear at the next edge
   wire pd_both = pd_up & pd_down;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pd_up <= 1'b0;
         pd_down <= 1'b0;
      end else if (ce) begin
         if (ref_pulse) begin
            pd_up <= 1'b1;
         end else if (pd_both) begin
            pd_up <= 1'b0;
         end
         if (md_p2) begin
            pd_down <= 1'b1;
         end else if (pd_both) begin
            pd_down <= 1'b0;
         end
      end
   end

   // Lock judged at each detector clear from the one-sided time
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         gap_count <= '0;
         lock_ok <= 1'b0;
      end else if (ce) begin
         if (pd_both) begin
            lock_ok <= (gap_count <= LOCK_MAX);
            gap_count <= '0;
         end else if ((pd_up ^ pd_down) && gap_count != LOCK_SAT) begin
            gap_count <= gap_count + 4'h1;
         end
      end
   end

   // Lock pin source; an unprogrammed test word gives the indicator
   wire [1:0] tsel = {test.test_select_hi, test.test_select_lo};
   wire lock_ind = ~setup.synth_enable | lock_ok;
   wire next_lock_out = (test.programmed && tsel == TSEL_REF) ? ref_pulse :
                        (test.programmed && tsel == TSEL_MAIN) ? md_p2 :
                        lock_ind;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lock_out <= 1'b1;
      end else if (ce) begin
         lock_out <= next_lock_out;
      end
   end

   // Enables and pump controls, all dead while disabled
   assign prescaler_enable = setup.synth_enable;
   assign ref_input_enable = setup.synth_enable;
   assign pump_output_up = pd_up & setup.synth_enable;
   assign pump_output_down = pd_down & setup.synth_enable;
   assign pump_current_level = setup.synth_enable ?
      working.pump_current_factor : 8'h00;
   assign comp_enable = setup.synth_enable &
      (md_p1 | md_p2 | md_p3);
   assign fraction_accumulator_value = acc;

endmodule : fns_synth_core
`default_nettype wire

// File: hdl/fns_pkg.sv
/*
 Shared constants and types for the fractional-N synthesizer core:
 serial word layouts, address codes, prescaler ratio codes, state codes.
 Assumes it is compiled before every other design file.
*/
package fns_pkg;

   // Serial word geometry
   localparam int WORD_W = 32;
   localparam int SHORT_W = 24;
   localparam int ADDR_W = 4;

   // Address codes: divider words carry one address bit, others four
   localparam logic ADDR_DIV = 1'b0;
   localparam logic [3:0] ADDR_PUMP = 4'h3;
   localparam logic [3:0] ADDR_SETUP = 4'h5;
   localparam logic [3:0] ADDR_TEST = 4'h7;

   // Prescaler type codes
   localparam logic [1:0] PR_THREE = 2'h2;

   // Ratio codes driven to the prescaler
   localparam logic [1:0] RATIO_64 = 2'h0;
   localparam logic [1:0] RATIO_65 = 2'h1;
   localparam logic [1:0] RATIO_72 = 2'h2;

   // Test output selections
   localparam logic [1:0] TSEL_REF = 2'h1;
   localparam logic [1:0] TSEL_MAIN = 2'h3;

   // Fraction moduli
   localparam logic [3:0] QMOD8 = 4'h8;
   localparam logic [3:0] QMOD5 = 4'h5;

   // Divider limits and offsets
   localparam logic [11:0] NR_MIN = 12'h004;
   localparam logic [12:0] M64_EXTRA = 13'h0002;
   localparam logic [12:0] M72_EXTRA = 13'h0001;
   localparam logic [12:0] COUNT_LAST = 13'h0001;
   localparam logic [11:0] REF_LAST = 12'h001;

   // Post-divider tap masks for ref_output_select 00..11 (1, 2, 4, 8)
   localparam logic [3:0][2:0] POST_MASK = {3'h7, 3'h3, 3'h1, 3'h0};

   // Lock: phase gap allowed, in reference input cycles
   localparam logic [3:0] LOCK_MAX = 4'h1;
   localparam logic [3:0] LOCK_SAT = 4'hF;

   // Word layouts as shifted in (address in the last bits sent)
   typedef struct packed {
      logic synth_enable;
      logic [1:0] ref_output_select;
      logic [11:0] ref_divide_ratio;
      logic fraction_modulus_select;
      logic word_format_select;
      logic [2:0] spare;
      logic [3:0] addr;
   } fns_setup_word_t;

   typedef struct packed {
      logic [7:0] pump_current_factor;
      logic [1:0] prescaler_select;
      logic [9:0] spare;
      logic [3:0] addr;
   } fns_pump_word_t;

   typedef struct packed {
      logic [17:0] spare;
      logic test_select_hi;
      logic test_select_lo;
      logic [3:0] addr;
   } fns_test_word_t;

   typedef struct packed {
      logic [11:0] mod64_cycle_count;
      logic [7:0] count_field;
      logic [2:0] fraction_increment;
      logic addr;
   } fns_short_divider_word_t;

   typedef struct packed {
      logic [7:0] pump_current_factor;
      fns_short_divider_word_t body;
   } fns_long_divider_word_t;

   // Held register groups
   typedef struct packed {
      logic synth_enable;
      logic [1:0] ref_output_select;
      logic [11:0] ref_divide_ratio;
      logic fraction_modulus_select;
      logic word_format_select;
   } fns_setup_t;

   typedef struct packed {
      logic programmed;
      logic test_select_hi;
      logic test_select_lo;
   } fns_test_t;

   typedef struct packed {
      logic [11:0] mod64_cycle_count;
      logic [7:0] mod65_cycle_count;
      logic [3:0] mod72_cycle_count;
      logic [1:0] prescaler_select;
      logic [2:0] fraction_increment;
      logic [7:0] pump_current_factor;
   } fns_div_cfg_t;

   // Main divider phases
   typedef enum logic [1:0] {
      MD_M65 = 2'b00,
      MD_M72 = 2'b01,
      MD_M64 = 2'b10
   } fns_md_state_t;

endpackage : fns_pkg

// File: hdl/fns_serial_shift.sv
/*
 Serial input shift register on the serial clock domain.
 Assumes data and latch_enable meet setup and hold to the serial clock,
 so they are sampled directly in that domain.
*/
`timescale 1ns/1ps
`default_nettype none

module fns_serial_shift
   import fns_pkg::*;
#(
   parameter int WIDTH = WORD_W
) (
   input wire logic serial_clk,
   input wire logic rst,
   input wire logic serial_data,
   input wire logic latch_enable,
   output logic [WIDTH-1:0] shift_word
);

   // Shift msb first; the word freezes while the latch is high
   always_ff @(posedge serial_clk or posedge rst) begin
      if (rst) begin
         shift_word <= '0;
      end else if (!latch_enable) begin
         shift_word <= {shift_word[WIDTH-2:0], serial_data};
      end
   end

endmodule : fns_serial_shift
`default_nettype wire

// File: verif/fns_core_sva.sv
/*
 Port checker for the synthesizer core, bound to every instance.
 Assumes clk is the reference clock and rst its asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none

module fns_core_sva
   import fns_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [1:0] prescaler_ratio,
   input wire logic prescaler_enable,
   input wire logic ref_input_enable,
   input wire logic pump_output_up,
   input wire logic pump_output_down,
   input wire logic [7:0] pump_current_level,
   input wire logic comp_enable,
   input wire logic [2:0] fraction_accumulator_value,
   input wire logic lock_out
);
   // Single domain, so one clocking and one disable
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   en_pair_a:
      assert property (prescaler_enable == ref_input_enable)
      else $error("input enables differ");
   off_quiet_a:
      assert property (!prescaler_enable |-> !pump_output_up
         && !pump_output_down && pump_current_level == 8'h00 && !comp_enable)
      else $error("pump active while disabled");
   ratio_code_a:
      assert property (prescaler_ratio != 2'h3)
      else $error("illegal prescaler ratio");
   ratio_hold_a:
      assert property ($changed(prescaler_ratio) |=> $stable(prescaler_ratio))
      else $error("ratio changed twice in a row");
   // Disable may cut the window short
   comp_win_a:
      assert property ($rose(comp_enable) |-> (comp_enable[*3] ##1
         !comp_enable) or (##[1:3] !prescaler_enable))
      else $error("bad compensation window");
   // A new reference edge may set one flop again in the clearing cycle
   pfd_clear_a:
      assert property (pump_output_up && pump_output_down |->
         ##1 !(pump_output_up && pump_output_down))
      else $error("detector not cleared");
   acc_pulse_a:
      assert property ($changed(fraction_accumulator_value) && prescaler_enable
         |-> ##[0:2] $rose(comp_enable))
      else $error("no compensation after cycle end");
   lock_off_a:
      assert property (!prescaler_enable && !$past(prescaler_enable, 3)
         |-> lock_out)
      else $error("lock low while disabled");
endmodule : fns_core_sva

bind fns_synth_core fns_core_sva u_sva (.clk, .rst, .prescaler_ratio,
   .prescaler_enable, .ref_input_enable, .pump_output_up, .pump_output_down,
   .pump_current_level, .comp_enable, .fraction_accumulator_value, .lock_out);

`default_nettype wire

// File: verif/fns_host_model.sv
/*
 Host controller model for the three-wire programming port.
 Assumes one caller at a time; the link clock runs only inside frames.
*/
`timescale 1ns/1ps
`default_nettype none

module fns_host_model
   import fns_pkg::*;
(
   output logic serial_clk,
   output logic serial_data,
   output logic latch_enable
);
   // Clock parked low, latch high keeps the shift register frozen
   initial begin
      serial_clk = 1'b0;
      serial_data = 1'b0;
      latch_enable = 1'b1;
   end

   // Msb first, address last, 32 ns link period
   task automatic send(input logic [WORD_W-1:0] w, input logic lw);
      latch_enable = 1'b0;
      for (int i = (lw ? WORD_W : SHORT_W) - 1; i >= 0; i--) begin
         serial_data = w[i];
         #16 serial_clk = 1'b1;
         #16 serial_clk = 1'b0;
      end
      // Latch stays high until the next word: covers divider reload
      #16 latch_enable = 1'b1;
      serial_data = ~serial_data;
   endtask : send
endmodule : fns_host_model

`default_nettype wire

// File: verif/test_fns_synth_core.sv
/*
 Self-checking bench for the synthesizer core.
 Assumes the host model and the bound checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module test_fns_synth_core
   import fns_pkg::*;
;
   logic clk, rst, pre, sclk, sdat, latch, prev_ovf;
   logic pre_en, ref_en, up, dn, comp, lock;
   logic [1:0] ratio;
   logic [7:0] pump;
   logic [2:0] acc;
   int n_fail = 0;
   int checks = 0;
   int pc = 0;

   fns_host_model host (.serial_clk(sclk), .serial_data(sdat),
      .latch_enable(latch));
   fns_synth_core DUT (.clk, .rst, .ce(1'b1), .serial_clk(sclk),
      .serial_data(sdat), .latch_enable(latch), .prescaler_out(pre),
      .divider_probe_input(1'b1), .prescaler_ratio(ratio),
      .prescaler_enable(pre_en), .ref_input_enable(ref_en),
      .pump_output_up(up), .pump_output_down(dn), .pump_current_level(pump),
      .comp_enable(comp), .fraction_accumulator_value(acc), .lock_out(lock));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Prescaler output, four reference cycles a period
   always @(negedge clk) begin
      pc <= pc + 1;
      if (pc[0]) pre <= ~pre;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [31:0] w, input logic lw);
      host.send(w, lw);
      repeat (8) @(negedge clk);
   endtask : wr

   task automatic setup(input logic en, input logic [1:0] sm,
         input logic fm, input logic lw);
      fns_setup_word_t s;
      s = '{en, sm, 12'h004, fm, lw, 3'h0, ADDR_SETUP};
      wr(32'(s), 1'b0);
   endtask : setup

   // One main cycle: step of the accumulator and cycles at 65 and 72
   task automatic win(input int q, input logic on, input int b65,
         input int b72);
      logic [2:0] a;
      int c65, c72, t, s;
      a = acc;
      c65 = 0;
      c72 = 0;
      t = 0;
      while (acc === a && t < 400) begin
         @(negedge clk);
         t++;
         if (ratio === RATIO_65) c65++;
         if (ratio === RATIO_72) c72++;
      end
      s = a + 3;
      chk(8'(t < 400), 8'h01);
      if (on) begin
         chk({5'h00, acc}, 8'(s % q));
         // A stretched cycle adds one prescaler period of four clocks
         chk(8'(c65), 8'(prev_ovf ? b65 + 4 : b65));
         chk(8'(c72), 8'(b72));
      end
      prev_ovf = on ? s >= q : acc < a;
   endtask : win

   // Rising edges on the lock pin over 64 cycles, within one of e
   task automatic rises(input int e);
      int r;
      logic l;
      r = 0;
      l = lock;
      repeat (64) begin
         @(negedge clk);
         if (lock && !l) r++;
         l = lock;
      end
      chk(8'(r >= e - 1 && r <= e + 1), 8'h01);
   endtask : rises

   task automatic summarize;
      if (n_fail == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : summarize

   initial begin
      #500000;
      n_fail++;
      summarize;
   end

   initial begin
      rst = 1'b1;
      pre = 1'b0;
      repeat (3) @(negedge clk);
      rst = 1'b0;
      chk({lock, pre_en, ref_en, comp, 1'b0, acc}, 8'h80);
      chk(pump, 8'h00);
      setup(1'b1, 2'h0, 1'b0, 1'b0);
      chk({6'h00, pre_en, ref_en}, 8'h03);
      wr(32'(fns_pump_word_t'{8'hA5, 2'h1, 10'h000, ADDR_PUMP}), 1'b0);
      chk(pump, 8'h00);
      wr(32'(fns_short_divider_word_t'{12'h000, 8'h02, 3'h3, ADDR_DIV}),
         1'b0);
      win(5, 1'b0, 0, 0);
      chk(pump, 8'hA5);
      repeat (3) win(5, 1'b1, 8, 0);
      setup(1'b1, 2'h0, 1'b1, 1'b1);
      wr(32'(fns_long_divider_word_t'{8'h3C,
         '{12'h000, 8'h02, 3'h3, ADDR_DIV}}), 1'b1);
      win(8, 1'b0, 0, 0);
      win(8, 1'b0, 0, 0);
      chk(pump, 8'h3C);
      repeat (3) win(8, 1'b1, 8, 0);
      for (int m = 0; m < 4; m++) begin
         setup(1'b1, 2'(m), 1'b1, 1'b1);
         wr(32'(fns_test_word_t'{18'h0, 1'b0, 1'b1, ADDR_TEST}), 1'b0);
         rises(16 >> m);
      end
      wr(32'(fns_test_word_t'{18'h0, 1'b1, 1'b1, ADDR_TEST}), 1'b0);
      rises(4);
      // Setup must hand the pin back to the slow lock indicator
      setup(1'b1, 2'h0, 1'b1, 1'b0);
      rises(1);
      // Three-modulus type: 65 count 1, 72 count 2 from the count field
      wr(32'(fns_pump_word_t'{8'h5A, 2'h2, 10'h000, ADDR_PUMP}), 1'b0);
      chk(pump, 8'h3C);
      wr(32'(fns_short_divider_word_t'{12'h000, 8'h21, 3'h3, ADDR_DIV}),
         1'b0);
      win(8, 1'b0, 0, 0);
      win(8, 1'b0, 0, 0);
      chk(pump, 8'h5A);
      repeat (3) win(8, 1'b1, 4, 12);
      setup(1'b0, 2'h0, 1'b1, 1'b1);
      rises(0);
      chk({lock, pre_en, 6'h00}, 8'h80);
      chk(pump, 8'h00);
      summarize;
   end
endmodule : test_fns_synth_core

`default_nettype wire
